//--- hw/hmdr_regs.sv
// Behaviour
// - Raw-mode frame start after minimum active time.
// - Pull-down on when pin is not output.
// - Per-pin disable bit turns pull-down off.
// - Read select field picks port debug copy.
// - Debug writes go to every enabled port.
// - Bit 5 shows remote self-test active.
// - Bit 1 corrupts every back-channel frame.
// - Bit 0 corrupts one frame, then clears.
// - Reserved locations read fixed defaults.
module hmdr_regs
   import hmdr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire hmdr_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic [3:0] rx_port_write_en,
   input wire logic [1:0] rx_port_read_sel,
   input wire logic [3:0] raw_mode,
   input wire logic [3:0] frame_active,
   input wire logic [3:0] bc_frame,
   input wire logic [3:0] remote_selftest,
   input wire logic [7:0] pin_output_mode,
   output logic [3:0] frame_start,
   output logic [3:0] bc_err_inject,
   output logic [7:0] pin_pulldown_en
);
   logic [7:0] fa_min_r;
   logic [7:0] pd_off_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [3:0] fa_s1_r;
   logic [3:0] fa_s2_r;
   logic [3:0] st_s1_r;
   logic [3:0] st_s2_r;
   logic [3:0] cont_v;
   logic [3:0] single_v;
   logic [3:0] port_wr;
   logic [7:0] dbg_rd;
   logic wr_fa;
   logic wr_pd;
   logic wr_dbg;
   logic rsvd_rng;

   // ==========================================================
   // Address decode
   assign wr_fa = reg_req.wr && reg_req.addr == HMDR_OFS_FA_MIN;
   assign wr_pd = reg_req.wr && reg_req.addr == HMDR_OFS_PD_CTRL;
   assign wr_dbg = reg_req.wr && reg_req.addr == HMDR_OFS_DEBUG;
   assign port_wr = {4{wr_dbg}} & rx_port_write_en;
   assign rsvd_rng = reg_req.addr >= HMDR_OFS_RSVD_LO &&
      reg_req.addr <= HMDR_OFS_RSVD_HI;

   // ==========================================================
   // Shared registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fa_min_r <= HMDR_RST_FA_MIN;
         pd_off_r <= HMDR_RST_ZERO;
      end else begin
         if (wr_fa) begin
            fa_min_r <= reg_req.wdata;
         end
         if (wr_pd) begin
            pd_off_r <= reg_req.wdata;
         end
      end
   end

   assign pin_pulldown_en = ~pin_output_mode & ~pd_off_r;

   // ==========================================================
   // Pin synchronisers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fa_s1_r <= 4'h0;
         fa_s2_r <= 4'h0;
         st_s1_r <= 4'h0;
         st_s2_r <= 4'h0;
      end else begin
         fa_s1_r <= frame_active;
         fa_s2_r <= fa_s1_r;
         st_s1_r <= remote_selftest;
         st_s2_r <= st_s1_r;
      end
   end

   // ==========================================================
   // Receive ports
   genvar gi;
   generate
      for (gi = 0; gi < HMDR_NPORT; gi++) begin : g_port
         hmdr_rx_port u_port (
            .mclk(mclk),
            .rst(rst),
            .raw_mode(raw_mode[gi]),
            .frame_active(fa_s2_r[gi]),
            .frame_active_min_time(fa_min_r),
            .bc_frame(bc_frame[gi]),
            .dbg_wr(port_wr[gi]),
            .dbg_wdata(reg_req.wdata),
            .frame_start(frame_start[gi]),
            .bc_err_inject(bc_err_inject[gi]),
            .backchan_err_continuous(cont_v[gi]),
            .backchan_err_single(single_v[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Read path
   assign dbg_rd = {2'b00, st_s2_r[rx_port_read_sel], 3'b000,
      cont_v[rx_port_read_sel], single_v[rx_port_read_sel]};
   assign rdata_nxt =
      !reg_req.rd ? rdata_r :
      reg_req.addr == HMDR_OFS_RSVD_BB ? HMDR_RST_RSVD_BB :
      reg_req.addr == HMDR_OFS_FA_MIN ? fa_min_r :
      reg_req.addr == HMDR_OFS_PD_CTRL ? pd_off_r :
      reg_req.addr == HMDR_OFS_DEBUG ? dbg_rd :
      HMDR_RST_ZERO;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_r <= HMDR_RST_ZERO;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_pd_write: assert property (
      wr_pd |=> pd_off_r == $past(reg_req.wdata))
      else $error("pull-down control not written");
   a_pd_output: assert property (
      (pin_pulldown_en & pin_output_mode) == 8'h00)
      else $error("pull-down on for output pin");
   a_rd_rsvd: assert property (
      reg_req.rd && (reg_req.addr == HMDR_OFS_RSVD_BB)
      |=> reg_rdata == HMDR_RST_RSVD_BB)
      else $error("reserved location read wrong");
   a_rd_rsvd_rng: assert property (
      reg_req.rd && rsvd_rng |=> reg_rdata == HMDR_RST_ZERO)
      else $error("reserved range not zero");
   a_rd_page: assert property (
      reg_req.rd && reg_req.addr == HMDR_OFS_DEBUG
      |=> reg_rdata[1] == $past(cont_v[rx_port_read_sel]))
      else $error("wrong port page read");
   a_rd_selftest: assert property (
      reg_req.rd && reg_req.addr == HMDR_OFS_DEBUG
      |=> reg_rdata[5] == $past(st_s2_r[rx_port_read_sel]))
      else $error("self-test bit wrong");
   a_wr_masked: assert property (
      wr_dbg && !rx_port_write_en[1] |=> cont_v[1] == $past(cont_v[1]))
      else $error("disabled port written");
   a_wr_enabled: assert property (
      wr_dbg && rx_port_write_en[0]
      |=> cont_v[0] == $past(reg_req.wdata[1]))
      else $error("enabled port not written");

   // ==========================================================
   // Further register and pin checks
   sequence s_dbg_read;
      reg_req.rd && reg_req.addr == HMDR_OFS_DEBUG;
   endsequence

   sequence s_single_write;
      wr_dbg && rx_port_write_en[0] && reg_req.wdata[HMDR_DBG_SINGLE];
   endsequence

   a_rd_fa_min: assert property (
      reg_req.rd && reg_req.addr == HMDR_OFS_FA_MIN
      |=> reg_rdata == $past(fa_min_r))
      else $error("minimum time read wrong");
   a_rd_pd: assert property (
      reg_req.rd && reg_req.addr == HMDR_OFS_PD_CTRL
      |=> reg_rdata == $past(pd_off_r))
      else $error("pull-down control read wrong");
   a_rd_bd: assert property (
      reg_req.rd && reg_req.addr == HMDR_OFS_RSVD_BD
      |=> reg_rdata == HMDR_RST_ZERO)
      else $error("reserved location not zero");
   a_rd_bf: assert property (
      reg_req.rd && reg_req.addr == HMDR_OFS_RSVD_BF
      |=> reg_rdata == HMDR_RST_ZERO)
      else $error("reserved location not zero");
   a_rd_dbg_rsvd: assert property (
      s_dbg_read |=> reg_rdata[7:6] == 2'b00 && reg_rdata[4:2] == 3'b000)
      else $error("debug reserved bits set");
   a_rd_single: assert property (
      s_dbg_read |=> reg_rdata[0] == $past(single_v[rx_port_read_sel]))
      else $error("wrong single bit read");
   a_rd_hold: assert property (
      !reg_req.rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   a_fa_write: assert property (
      wr_fa |=> fa_min_r == $past(reg_req.wdata))
      else $error("minimum time not written");
   a_fa_hold: assert property (
      !wr_fa |=> $stable(fa_min_r))
      else $error("minimum time changed without write");
   a_pd_hold: assert property (
      !wr_pd |=> $stable(pd_off_r))
      else $error("pull-down control changed without write");
   a_pd_off: assert property (
      (pin_pulldown_en & pd_off_r) == 8'h00)
      else $error("pull-down on for disabled pin");
   a_pd_input: assert property (
      (~pin_output_mode & ~pd_off_r & ~pin_pulldown_en) == 8'h00)
      else $error("pull-down off for input pin");
   a_wr_idle: assert property (
      !wr_dbg |=> $stable(cont_v))
      else $error("port debug changed without write");
   a_wr_port2: assert property (
      wr_dbg && rx_port_write_en[2]
      |=> cont_v[2] == $past(reg_req.wdata[HMDR_DBG_CONT]))
      else $error("enabled port not written");
   a_single_set: assert property (
      s_single_write |=> single_v[0])
      else $error("single error request lost");
   a_inj_gate: assert property (
      (bc_err_inject & ~bc_frame) == 4'h0)
      else $error("error injected outside a frame");
endmodule

//--- hw/hmdr_pkg.sv
package hmdr_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] HMDR_OFS_RSVD_BB = 8'hBB;
   localparam logic [7:0] HMDR_OFS_FA_MIN = 8'hBC;
   localparam logic [7:0] HMDR_OFS_RSVD_BD = 8'hBD;
   localparam logic [7:0] HMDR_OFS_PD_CTRL = 8'hBE;
   localparam logic [7:0] HMDR_OFS_RSVD_BF = 8'hBF;
   localparam logic [7:0] HMDR_OFS_RSVD_LO = 8'hC0;
   localparam logic [7:0] HMDR_OFS_RSVD_HI = 8'hCF;
   localparam logic [7:0] HMDR_OFS_DEBUG = 8'hD0;

   // ==========================================================
   // Reset and fixed read values
   localparam logic [7:0] HMDR_RST_RSVD_BB = 8'h74;
   localparam logic [7:0] HMDR_RST_FA_MIN = 8'h80;
   localparam logic [7:0] HMDR_RST_ZERO = 8'h00;

   // ==========================================================
   // Debug register fields
   localparam int HMDR_DBG_SINGLE = 0;
   localparam int HMDR_DBG_CONT = 1;
   localparam int HMDR_DBG_SELFTEST = 5;

   localparam int HMDR_NPORT = 4;
   localparam int HMDR_NPIN = 8;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hmdr_req_t;
endpackage

//--- hw/hmdr_rx_port.sv
module hmdr_rx_port
   import hmdr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic raw_mode,
   input wire logic frame_active,
   input wire logic [7:0] frame_active_min_time,
   input wire logic bc_frame,
   input wire logic dbg_wr,
   input wire logic [7:0] dbg_wdata,
   output logic frame_start,
   output logic bc_err_inject,
   output logic backchan_err_continuous,
   output logic backchan_err_single
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic fired_r;
   logic cont_r;
   logic single_r;
   logic single_nxt;
   logic cnt_max;

   // ==========================================================
   // Frame start gate
   assign cnt_max = (cnt_r == 8'hFF);
   assign frame_start = raw_mode && frame_active && !fired_r &&
      (cnt_r >= frame_active_min_time);
   assign cnt_nxt = !frame_active ? 8'h00 :
      (cnt_max ? cnt_r : cnt_r + 8'h01);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
         fired_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         fired_r <= frame_active && (fired_r || frame_start);
      end
   end

   // ==========================================================
   // Back-channel error injection
   assign bc_err_inject = bc_frame && (cont_r || single_r);
   // Set by a write wins over the clear by an injection
   assign single_nxt = (dbg_wr && dbg_wdata[HMDR_DBG_SINGLE]) ||
      (single_r && !bc_frame);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cont_r <= 1'b0;
         single_r <= 1'b0;
      end else begin
         single_r <= single_nxt;
         if (dbg_wr) begin
            cont_r <= dbg_wdata[HMDR_DBG_CONT];
         end
      end
   end

   assign backchan_err_continuous = cont_r;
   assign backchan_err_single = single_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_fa_begin;
      !frame_active ##1 frame_active;
   endsequence

   a_fs_min_time: assert property (
      frame_start |-> cnt_r >= frame_active_min_time && raw_mode)
      else $error("frame start before minimum time");
   a_fs_zero_min: assert property (
      s_fa_begin ##0 (raw_mode && frame_active_min_time == 8'h00)
      |-> frame_start)
      else $error("frame start missing with zero minimum");
   a_fs_once: assert property (
      frame_start |=> !frame_start)
      else $error("frame start repeated in one frame");
   a_bc_cont: assert property (
      cont_r && bc_frame && !dbg_wr |-> bc_err_inject ##1 cont_r)
      else $error("continuous error not injected");
   a_bc_single: assert property (
      single_r && bc_frame && !dbg_wr |-> bc_err_inject ##1 !single_r)
      else $error("single error not injected once");
   a_bc_none: assert property (
      !cont_r && !single_r |-> !bc_err_inject)
      else $error("error injected while idle");
endmodule

//--- testbench/hmdr_host.sv
module hmdr_host
   import hmdr_pkg::*;
(
   input wire logic mclk,
   input wire logic [7:0] rdata,
   output hmdr_req_t req
);
   timeunit 1ns;
   timeprecision 1ns;

   initial req = '0;

   // ==========================================================
   // Register access, each request held for one cycle, then one idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge mclk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge mclk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      d = rdata;
   endtask
endmodule

//--- testbench/hub_misc_and_port_debug_regs_tb.sv
module hub_misc_and_port_debug_regs_tb
   import hmdr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk = 1'b0;
   logic rst = 1'b1;
   hmdr_req_t reg_req;
   logic [7:0] reg_rdata, pin_output_mode, pin_pulldown_en, d;
   logic [3:0] write_en, raw_mode, frame_active, bc_frame;
   logic [3:0] remote_selftest, frame_start, bc_err_inject;
   logic [1:0] read_sel;
   int n_errors = 0;
   int total_checks = 0;
   int starts, late, first, lo;
   logic [7:0] adr [9] = '{8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC0,
      8'hCF, 8'hD0, 8'h10};
   logic [7:0] rstv [9] = '{8'h74, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};
   logic [7:0] page [4] = '{8'h02, 8'h20, 8'h02, 8'h00};

   hmdr_host host(.mclk(mclk), .rdata(reg_rdata), .req(reg_req));

   hmdr_regs dut(.mclk(mclk), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .rx_port_write_en(write_en),
      .rx_port_read_sel(read_sel), .raw_mode(raw_mode),
      .frame_active(frame_active), .bc_frame(bc_frame),
      .remote_selftest(remote_selftest),
      .pin_output_mode(pin_output_mode), .frame_start(frame_start),
      .bc_err_inject(bc_err_inject), .pin_pulldown_en(pin_pulldown_en));

   initial begin
      forever #20 mclk = ~mclk;
   end

   // ==========================================================
   // Compare and helpers
   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d);
      chk("reg_rdata", e, d);
   endtask

   task automatic frame(input logic [3:0] f, input logic [3:0] e);
      @(negedge mclk);
      bc_frame = f;
      #1 chk("bc_err_inject", {4'h0, e}, {4'h0, bc_err_inject});
      @(negedge mclk);
      bc_frame = 4'h0;
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      finish_test;
   end

   // ==========================================================
   // Test sequence
   initial begin
      {write_en, raw_mode, frame_active, bc_frame} = '0;
      read_sel = 2'd0;
      remote_selftest = 4'b0010;
      pin_output_mode = 8'h0F;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      for (int i = 0; i < 9; i++) rdchk(adr[i], rstv[i]);
      host.wr(8'hBB, 8'hFF);
      rdchk(8'hBB, 8'h74);
      host.wr(8'hBE, 8'h55);
      #1 chk("pin_pulldown_en", 8'hA0, pin_pulldown_en);
      rdchk(8'hBE, 8'h55);
      write_en = 4'b0101;
      host.wr(8'hD0, 8'h02);
      for (int p = 0; p < 4; p++) begin
         read_sel = p[1:0];
         rdchk(8'hD0, page[p]);
      end
      frame(4'b0011, 4'b0001);
      frame(4'b0101, 4'b0101);
      host.wr(8'hD0, 8'h00);
      frame(4'b0001, 4'b0000);
      write_en = 4'b0001;
      host.wr(8'hD0, 8'h01);
      read_sel = 2'd0;
      rdchk(8'hD0, 8'h01);
      frame(4'b0001, 4'b0001);
      frame(4'b0001, 4'b0000);
      rdchk(8'hD0, 8'h00);
      raw_mode = 4'b0111;
      for (int f = 0; f < 2; f++) begin
         lo = (f == 0) ? 3 : 0;
         host.wr(8'hBC, 8'(lo));
         starts = 0;
         late = 0;
         first = 99;
         frame_active = 4'b1100;
         for (int c = 0; c < 20; c++) begin
            @(negedge mclk);
            if (frame_start[2] === 1'b1 && first == 99) first = c;
            starts += int'(frame_start[2] === 1'b1);
            late += int'(frame_start[3] !== 1'b0);
         end
         chk("frame_start count", 8'd1, 8'(starts));
         first = int'(first >= lo && first < lo + 6);
         chk("frame_start early", 8'd1, 8'(first));
         chk("frame_start non-raw", 8'd0, 8'(late));
         frame_active = 4'h0;
         repeat (4) @(negedge mclk);
      end
      host.wr(8'hD0, 8'h02);
      @(negedge mclk);
      bc_frame = 4'b0001;
      rst = 1'b1;
      #1 chk("bc_err_inject", 8'h00, {4'h0, bc_err_inject});
      chk("pin_pulldown_en", 8'hF0, pin_pulldown_en);
      @(negedge mclk);
      bc_frame = 4'h0;
      rst = 1'b0;
      rdchk(8'hD0, 8'h00);
      rdchk(8'hBE, 8'h00);
      finish_test;
   end
endmodule
